// ==== core/fec_cfg.svh ====
`ifndef FEC_CFG_SVH
`define FEC_CFG_SVH

// register byte addresses (full 32-bit addresses, all bits compared on the bus)
`define FEC_ADDR_PF_CTRL 32'hFFFF_FE60
`define FEC_ADDR_DF_CTRL 32'hFFFF_FE64
`define FEC_ADDR_PF_KEY 32'h0FFF_FE68
// control register fields
`define FEC_BIT_BUSY 11
`define FEC_BIT_INFO 10
`define FEC_BIT_PAGE 9
`define FEC_BIT_MASS 8
`define FEC_PF_RSV_HI 7
`define FEC_PF_RSV_LO 5
`define FEC_PF_SEL_W 5
`define FEC_DF_SEL_W 6
// program flash write command register (added), key value
`define FEC_ADDR_PF_WRITE 32'hFFFF_FE6C
`define FEC_KEY_VALUE 32'h42DC_157E
`define FEC_ZERO32 32'h0000_0000
// erase and write cycle times in ns
`define FEC_PAGE_ERASE_NS 20000
`define FEC_MASS_ERASE_NS 200000
`define FEC_WRITE_NS 300
`define FEC_CLK_NS 10
`define FEC_CYC(ns) (((ns) + `FEC_CLK_NS - 1) / `FEC_CLK_NS)

`endif

// ==== core/fec_flash_ctrl.sv ====
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "fec_cfg.svh"
module fec_flash_ctrl
   import fec_pkg::*;
#(
   parameter int PAGE_CYC = `FEC_CYC(`FEC_PAGE_ERASE_NS),
   parameter int MASS_CYC = `FEC_CYC(`FEC_MASS_ERASE_NS)
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire fec_pkg::fec_word_t wb_dat_i,
   output fec_pkg::fec_word_t wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   output logic pf_info_sel,
   output logic df_info_sel,
   output logic pf_erase_page,
   output logic pf_erase_mass,
   output logic df_erase_page,
   output logic df_erase_mass,
   output logic [4:0] pf_page_sel,
   output logic [5:0] df_page_sel,
   output logic pf_write_strobe,
   output logic pf_busy,
   output logic df_busy
);
   import fec_pkg::*;

   localparam int WRITE_CYC = `FEC_CYC(`FEC_WRITE_NS);

   // registers
   logic pf_info_r, pf_info_nxt, df_info_r, df_info_nxt;
   logic pf_page_r, pf_page_nxt, pf_mass_r, pf_mass_nxt;
   logic df_page_r, df_page_nxt, df_mass_r, df_mass_nxt;
   logic [2:0] pf_rsv_r, pf_rsv_nxt;
   logic [4:0] pf_sel_r, pf_sel_nxt;
   logic [5:0] df_sel_r, df_sel_nxt;
   fec_word_t key_r, key_nxt;
   fec_word_t dat_r, dat_nxt;
   logic ack_r, ack_nxt, err_r, err_nxt;
   logic wstb_r, wstb_nxt;
   fec_state_e pf_st_r, pf_st_nxt, df_st_r, df_st_nxt;
   logic [31:0] pf_cnt_r, pf_cnt_nxt, df_cnt_r, df_cnt_nxt;
   logic pf_busy_r, pf_busy_nxt, df_busy_r, df_busy_nxt;

   logic req, wr, hit_pf, hit_df, hit_key, hit_wr;
   logic pf_done, df_done;
   logic [31:0] wmask;
   assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
   assign wr = req && wb_we_i;
   assign hit_pf = wb_adr_i == `FEC_ADDR_PF_CTRL;
   assign hit_df = wb_adr_i == `FEC_ADDR_DF_CTRL;
   assign hit_key = wb_adr_i == `FEC_ADDR_PF_KEY;
   assign hit_wr = wb_adr_i == `FEC_ADDR_PF_WRITE;
   assign pf_done = (pf_st_r != FEC_IDLE) && (pf_cnt_r == 32'h0000_0001);
   assign df_done = (df_st_r != FEC_IDLE) && (df_cnt_r == 32'h0000_0001);

   // byte-lane mask from sel
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_mask
         assign wmask[8*g +: 8] = {8{wb_sel_i[g]}};
      end
   endgenerate

   // bus slave and register next values
   always_comb begin
      logic [31:0] pfw, dfw;
      pfw = (wb_dat_i & wmask) | ({20'h0_0000, pf_busy, pf_info_r, pf_page_r, pf_mass_r, pf_rsv_r, pf_sel_r} & ~wmask);
      dfw = (wb_dat_i & wmask) | ({20'h0_0000, df_busy, df_info_r, df_page_r, df_mass_r, 2'b00, df_sel_r} & ~wmask);
      pf_info_nxt = pf_info_r;
      df_info_nxt = df_info_r;
      pf_page_nxt = pf_page_r && !pf_done;
      pf_mass_nxt = pf_mass_r && !pf_done;
      df_page_nxt = df_page_r && !df_done;
      df_mass_nxt = df_mass_r && !df_done;
      pf_rsv_nxt = pf_rsv_r;
      pf_sel_nxt = pf_sel_r;
      df_sel_nxt = df_sel_r;
      key_nxt = key_r;
      wstb_nxt = 1'b0;
      ack_nxt = 1'b0;
      err_nxt = 1'b0;
      dat_nxt = `FEC_ZERO32;
      if (req) begin
         ack_nxt = hit_pf || hit_df || hit_key || hit_wr;
         err_nxt = !(hit_pf || hit_df || hit_key || hit_wr);
      end
      // writes to a busy array's control are ignored so a running erase is not disturbed
      if (wr && hit_pf && !pf_busy) begin
         pf_info_nxt = pfw[`FEC_BIT_INFO];
         pf_page_nxt = pfw[`FEC_BIT_PAGE] && !pfw[`FEC_BIT_MASS];
         pf_mass_nxt = pfw[`FEC_BIT_MASS];
         pf_rsv_nxt = pfw[`FEC_PF_RSV_HI:`FEC_PF_RSV_LO];
         pf_sel_nxt = pfw[`FEC_PF_SEL_W-1:0];
      end
      if (wr && hit_df && !df_busy) begin
         df_info_nxt = dfw[`FEC_BIT_INFO];
         df_page_nxt = dfw[`FEC_BIT_PAGE] && !dfw[`FEC_BIT_MASS];
         df_mass_nxt = dfw[`FEC_BIT_MASS];
         df_sel_nxt = dfw[`FEC_DF_SEL_W-1:0];
      end
      if (wr && hit_key) begin
         key_nxt = (key_r & ~wmask) | (wb_dat_i & wmask);
      end
      // a write request only proceeds with the key loaded and the array idle
      if (wr && hit_wr && !pf_busy && key_r == `FEC_KEY_VALUE) begin
         wstb_nxt = 1'b1;
      end
      if (pf_st_r == FEC_WRITE && pf_done) begin
         key_nxt = `FEC_ZERO32;
      end
      if (req && !wb_we_i) begin
         unique case (1'b1)
            hit_pf: dat_nxt = {20'h0_0000, pf_busy, pf_info_r, pf_page_r, pf_mass_r, pf_rsv_r, pf_sel_r};
            hit_df: dat_nxt = {20'h0_0000, df_busy, df_info_r, df_page_r, df_mass_r, 2'b00, df_sel_r};
            hit_key: dat_nxt = key_r;
            default: dat_nxt = `FEC_ZERO32;
         endcase
      end
   end

   // program flash sequencer: start is the cycle after the trigger bit is set
   always_comb begin
      pf_st_nxt = pf_st_r;
      pf_cnt_nxt = pf_cnt_r;
      unique case (pf_st_r)
         FEC_IDLE: begin
            if (pf_mass_r) begin
               pf_st_nxt = FEC_MASS;
               pf_cnt_nxt = 32'(MASS_CYC);
            end else if (pf_page_r) begin
               pf_st_nxt = FEC_PAGE;
               pf_cnt_nxt = 32'(PAGE_CYC);
            end else if (wstb_r) begin
               pf_st_nxt = FEC_WRITE;
               pf_cnt_nxt = 32'(WRITE_CYC);
            end
         end
         FEC_PAGE, FEC_MASS, FEC_WRITE: begin
            pf_cnt_nxt = pf_cnt_r - 32'h0000_0001;
            if (pf_done) begin
               pf_st_nxt = FEC_IDLE;
            end
         end
         default: pf_st_nxt = FEC_IDLE;
      endcase
   end

   // data flash sequencer: erase only; data writes are not interlocked
   always_comb begin
      df_st_nxt = df_st_r;
      df_cnt_nxt = df_cnt_r;
      unique case (df_st_r)
         FEC_IDLE: begin
            if (df_mass_r) begin
               df_st_nxt = FEC_MASS;
               df_cnt_nxt = 32'(MASS_CYC);
            end else if (df_page_r) begin
               df_st_nxt = FEC_PAGE;
               df_cnt_nxt = 32'(PAGE_CYC);
            end
         end
         FEC_PAGE, FEC_MASS: begin
            df_cnt_nxt = df_cnt_r - 32'h0000_0001;
            if (df_done) begin
               df_st_nxt = FEC_IDLE;
            end
         end
         default: df_st_nxt = FEC_IDLE;
      endcase
   end

   // all state registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pf_info_r <= 1'b0;
         df_info_r <= 1'b0;
         pf_page_r <= 1'b0;
         pf_mass_r <= 1'b0;
         df_page_r <= 1'b0;
         df_mass_r <= 1'b0;
         pf_rsv_r <= 3'h0;
         pf_sel_r <= 5'h00;
         df_sel_r <= 6'h00;
         key_r <= `FEC_ZERO32;
         dat_r <= `FEC_ZERO32;
         ack_r <= 1'b0;
         err_r <= 1'b0;
         wstb_r <= 1'b0;
         pf_st_r <= FEC_IDLE;
         df_st_r <= FEC_IDLE;
         pf_cnt_r <= `FEC_ZERO32;
         df_cnt_r <= `FEC_ZERO32;
         pf_busy_r <= 1'b0;
         df_busy_r <= 1'b0;
      end else begin
         pf_info_r <= pf_info_nxt;
         df_info_r <= df_info_nxt;
         pf_page_r <= pf_page_nxt;
         pf_mass_r <= pf_mass_nxt;
         df_page_r <= df_page_nxt;
         df_mass_r <= df_mass_nxt;
         pf_rsv_r <= pf_rsv_nxt;
         pf_sel_r <= pf_sel_nxt;
         df_sel_r <= df_sel_nxt;
         key_r <= key_nxt;
         dat_r <= dat_nxt;
         ack_r <= ack_nxt;
         err_r <= err_nxt;
         wstb_r <= wstb_nxt;
         pf_st_r <= pf_st_nxt;
         df_st_r <= df_st_nxt;
         pf_cnt_r <= pf_cnt_nxt;
         df_cnt_r <= df_cnt_nxt;
         pf_busy_r <= pf_busy_nxt;
         df_busy_r <= df_busy_nxt;
      end
   end

   // busy covers a pending trigger too, so software never sees a gap;
   // built from next values so the registered copy tracks the live state with no lag
   assign pf_busy_nxt = pf_st_nxt != FEC_IDLE || pf_page_nxt || pf_mass_nxt || wstb_nxt;
   assign df_busy_nxt = df_st_nxt != FEC_IDLE || df_page_nxt || df_mass_nxt;
   assign pf_busy = pf_busy_r;
   assign df_busy = df_busy_r;
   assign wb_dat_o = dat_r;
   assign wb_ack_o = ack_r;
   assign wb_err_o = err_r;
   assign pf_info_sel = pf_info_r;
   assign df_info_sel = df_info_r;
   assign pf_erase_page = pf_page_r;
   assign pf_erase_mass = pf_mass_r;
   assign df_erase_page = df_page_r;
   assign df_erase_mass = df_mass_r;
   assign pf_page_sel = pf_sel_r;
   assign df_page_sel = df_sel_r;
   assign pf_write_strobe = wstb_r;

   // checks
   chk_pf_page_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (pf_st_r == FEC_PAGE && pf_done) |=> !pf_page_r && pf_st_r == FEC_IDLE)
      else $error("page erase bit not cleared at end");
   chk_pf_mass_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (pf_st_r == FEC_MASS && pf_done) |=> !pf_mass_r)
      else $error("mass erase bit not cleared at end");
   chk_df_page_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (df_st_r == FEC_PAGE && df_done) |=> !df_page_r)
      else $error("data page erase bit not cleared");
   chk_df_mass_end: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (df_st_r == FEC_MASS && df_done) |=> !df_mass_r)
      else $error("data mass erase bit not cleared");
   chk_pf_busy_erase: assert property (@(posedge sys_clk) disable iff (!rst_b)
      $rose(pf_page_r) |-> pf_busy ##1 (pf_st_r == FEC_PAGE && pf_busy))
      else $error("program busy not shown during erase");
   chk_df_busy_idle: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (df_st_r == FEC_IDLE && !df_page_r && !df_mass_r) |-> !df_busy)
      else $error("data busy set while idle");
   chk_key_blocks: assert property (@(posedge sys_clk) disable iff (!rst_b)
      wstb_r |-> $past(key_r) == `FEC_KEY_VALUE)
      else $error("write proceeded without key");
   chk_key_clear: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (pf_st_r == FEC_WRITE && pf_done) |=> key_r == `FEC_ZERO32)
      else $error("key not cleared after write");
   chk_info_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wr && hit_pf && !pf_busy) |=> pf_info_sel == $past(wb_sel_i[`FEC_BIT_INFO / 8] ? wb_dat_i[`FEC_BIT_INFO] : pf_info_r))
      else $error("info select not written");
   chk_df_info_sel: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wr && hit_df && !df_busy) |=> df_info_sel == $past(wb_sel_i[`FEC_BIT_INFO / 8] ? wb_dat_i[`FEC_BIT_INFO] : df_info_r))
      else $error("data info select not written");
   chk_pf_busy_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
      pf_write_strobe |-> pf_busy ##1 (pf_st_r == FEC_WRITE && pf_busy))
      else $error("program busy not shown during write");
   chk_df_busy_erase: assert property (@(posedge sys_clk) disable iff (!rst_b)
      ($rose(df_page_r) || $rose(df_mass_r)) |-> df_busy ##1 (df_st_r != FEC_IDLE && df_busy))
      else $error("data busy not shown during erase");
   chk_df_sel_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
      (wr && hit_df && !df_busy && wb_sel_i[0]) |=> df_page_sel == $past(wb_dat_i[`FEC_DF_SEL_W-1:0]))
      else $error("data page selector not written");
   // main scenarios: every erase kind ends and a keyed write completes
   cov_pf_page: cover property (@(posedge sys_clk) disable iff (!rst_b) pf_st_r == FEC_PAGE && pf_done);
   cov_pf_mass: cover property (@(posedge sys_clk) disable iff (!rst_b) pf_st_r == FEC_MASS && pf_done);
   cov_df_page: cover property (@(posedge sys_clk) disable iff (!rst_b) df_st_r == FEC_PAGE && df_done);
   cov_df_mass: cover property (@(posedge sys_clk) disable iff (!rst_b) df_st_r == FEC_MASS && df_done);
   cov_pf_write: cover property (@(posedge sys_clk) disable iff (!rst_b) pf_st_r == FEC_WRITE && pf_done);
endmodule
`default_nettype wire

// ==== core/fec_pkg.sv ====
package fec_pkg;
   typedef enum logic [3:0] {
      FEC_IDLE = 4'b0001,
      FEC_PAGE = 4'b0010,
      FEC_MASS = 4'b0100,
      FEC_WRITE = 4'b1000
   } fec_state_e;
   typedef logic [31:0] fec_word_t;
endpackage

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fec_cfg.svh"
module tb;
   import fec_pkg::*;
   // short erase counts keep the run brief; expectations do not depend on the exact figure
   localparam int PAGE_N = 8;
   localparam int MASS_N = 16;
   localparam logic [31:0] R_ADR [6] = '{`FEC_ADDR_PF_CTRL, `FEC_ADDR_DF_CTRL, `FEC_ADDR_PF_CTRL,
      `FEC_ADDR_DF_CTRL, `FEC_ADDR_PF_KEY, `FEC_ADDR_PF_KEY};
   localparam logic [31:0] R_WD [6] = '{32'h0000_04FF, 32'h0000_04FF, 32'h0000_0815, 32'h0000_0000,
      32'h1234_5678, 32'h0000_0000};
   localparam logic [31:0] R_EX [6] = '{32'h0000_04FF, 32'h0000_043F, 32'h0000_0015, 32'h0000_0000,
      32'h1234_5678, 32'h0000_0000};
   logic sys_clk, rst_b, cyc, stb, we, ack, err, e;
   logic pf_info, df_info, pf_pe, pf_me, df_pe, df_me, strobe, pf_busy, df_busy;
   logic [31:0] adr;
   logic [3:0] sel;
   logic [4:0] pf_sel;
   logic [5:0] df_sel;
   fec_word_t dat_w, dat_r, rd;
   int failures = 0;
   int n_checks = 0;
   int n_strobe = 0;
   int bitn;

   fec_flash_ctrl #(.PAGE_CYC(PAGE_N), .MASS_CYC(MASS_N)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
      .wb_dat_o(dat_r), .wb_ack_o(ack), .wb_err_o(err), .pf_info_sel(pf_info), .df_info_sel(df_info),
      .pf_erase_page(pf_pe), .pf_erase_mass(pf_me), .df_erase_page(df_pe), .df_erase_mass(df_me),
      .pf_page_sel(pf_sel), .df_page_sel(df_sel), .pf_write_strobe(strobe), .pf_busy(pf_busy),
      .df_busy(df_busy));

   // free-running system clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // count accepted program flash writes; the strobe stands one cycle only
   always @(posedge sys_clk) begin
      if (strobe === 1'b1) n_strobe <= n_strobe + 1;
   end

   task automatic conclude;
      if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         failures++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   // classic wishbone cycle: request held until ack or err is sampled high, or dropped as a timeout after 20 cycles
   task automatic wb(input logic w, input logic [31:0] a, input fec_word_t d);
      int n;
      @(posedge sys_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      sel <= 4'hF;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 20);
      rd = dat_r;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1 && err !== 1'b1) begin
         chk(1'b0, "bus timeout");
         conclude();
      end
   endtask

   // bounded wait until both arrays report idle
   task automatic wait_idle;
      int n;
      n = 0;
      while ((pf_busy !== 1'b0 || df_busy !== 1'b0) && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 400) begin
         chk(1'b0, "busy timeout");
         conclude();
      end
   endtask

   initial begin
      rst_b = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 32'h0000_0000;
      sel = 4'h0;
      dat_w = 32'h0000_0000;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      chk({pf_info, df_info, pf_pe, pf_me, df_pe, df_me, pf_sel, df_sel, pf_busy, df_busy} === 0, "reset outputs");
      // plain register rows: expected value against read-back and the field outputs
      for (int i = 0; i < 6; i++) begin
         wb(1'b1, R_ADR[i], R_WD[i]);
         wb(1'b0, R_ADR[i], 32'h0000_0000);
         chk(rd === R_EX[i], "register readback");
         if (R_ADR[i] == `FEC_ADDR_PF_CTRL) chk({pf_info, pf_sel} === {R_EX[i][10], R_EX[i][4:0]}, "pf fields");
         if (R_ADR[i] == `FEC_ADDR_DF_CTRL) chk({df_info, df_sel} === {R_EX[i][10], R_EX[i][5:0]}, "df fields");
      end
      wb(1'b0, 32'hFFFF_FE70, 32'h0000_0000);
      chk(e === 1'b1, "unmapped address not refused");
      // erase kinds: pf page, pf mass, df page, df mass; trigger self-clears at the end
      for (int k = 0; k < 4; k++) begin
         bitn = (k % 2 == 0) ? 9 : 8;
         wb(1'b1, (k < 2) ? `FEC_ADDR_PF_CTRL : `FEC_ADDR_DF_CTRL, (32'h1 << bitn) | 32'h0000_000A);
         @(negedge sys_clk);
         chk({pf_pe, pf_me, df_pe, df_me} === (4'b1000 >> k), "erase trigger output");
         wb(1'b0, (k < 2) ? `FEC_ADDR_PF_CTRL : `FEC_ADDR_DF_CTRL, 32'h0000_0000);
         chk(rd[11] === 1'b1 && rd[bitn] === 1'b1, "busy or trigger not set");
         wait_idle();
         wb(1'b0, (k < 2) ? `FEC_ADDR_PF_CTRL : `FEC_ADDR_DF_CTRL, 32'h0000_0000);
         chk(rd[11:8] === 4'h0 && rd[4:0] === 5'h0A, "trigger not cleared");
      end
      // write without the key, and with a near-miss key, must not reach the array
      wb(1'b1, `FEC_ADDR_PF_WRITE, 32'h0000_0000);
      wb(1'b1, `FEC_ADDR_PF_KEY, `FEC_KEY_VALUE ^ 32'h0000_0001);
      wb(1'b1, `FEC_ADDR_PF_WRITE, 32'h0000_0000);
      repeat (40) @(posedge sys_clk);
      chk(n_strobe === 0, "write not blocked");
      wb(1'b1, `FEC_ADDR_PF_KEY, `FEC_KEY_VALUE);
      wb(1'b0, `FEC_ADDR_PF_KEY, 32'h0000_0000);
      chk(rd === `FEC_KEY_VALUE, "key readback");
      wb(1'b1, `FEC_ADDR_PF_WRITE, 32'h0000_0000);
      @(negedge sys_clk);
      chk(pf_busy === 1'b1, "busy during write");
      wait_idle();
      chk(n_strobe === 1, "keyed write lost");
      wb(1'b0, `FEC_ADDR_PF_KEY, `FEC_ZERO32);
      chk(rd === `FEC_ZERO32, "key not cleared");
      wb(1'b1, `FEC_ADDR_PF_WRITE, 32'h0000_0000);
      repeat (40) @(posedge sys_clk);
      chk(n_strobe === 1, "second write without key");
      // reset in mid-run, with an erase running and fields set
      wb(1'b1, `FEC_ADDR_PF_KEY, 32'h0000_5555);
      wb(1'b1, `FEC_ADDR_DF_CTRL, 32'h0000_0533);
      @(posedge sys_clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(negedge sys_clk);
      chk({df_info, df_pe, df_me, df_sel, df_busy} === 0, "df outputs after reset");
      wb(1'b0, `FEC_ADDR_DF_CTRL, 32'h0000_0000);
      chk(rd === 32'h0000_0000, "df ctrl after reset");
      wb(1'b0, `FEC_ADDR_PF_KEY, 32'h0000_0000);
      chk(rd === 32'h0000_0000, "key after reset");
      conclude();
   end
endmodule
`default_nettype wire
